// [umcs_top.sv]
// Modem control and status logic for one channel, APB reachable
// How it works
// R1: Control bit 7 chooses undivided or divide-by-four clock for baud generator.
// R2: Control bit 6 high opens access to flow threshold and trigger registers.
// R3: Control bit 5 enables resume of halted transmission on any character.
// R4: Control bits 7..5 writable only while enhanced feature bit 4 set.
// R5: Control bit 4 loops TX to RX and control bits to status.
// R6: Loop-back status 7,6,5,4 equal control 3,2,0,1.
// R7: Control bit 3 low floats irq outputs, output pin high; high reverses.
// R8: Control bit 2 enables the FIFO ready summary register.
// R9: Control bit 1 drives RTS low when set unless auto RTS owns it.
// R10: Control bit 0 drives DTR low when set.
// R11: Outside loop-back status 7..4 show inverted CD, RI, DSR, CTS inputs.
// R12: Delta CD, DSR, CTS flags set on any change, cleared by read.
// R13: Delta RI flag set only on low-to-high of RI source, cleared by read.
// R14: Enable bits 7,6,5 gate CTS, RTS, Xoff interrupts; reset disabled.
// R15: CTS and RTS interrupts fire on active-to-inactive line change.
// R16: Channel interrupt active when any enabled source that is not masked fires.
// R17: Enable bits 7..4 writable only while enhanced feature bit 4 set.
// R18: Status read returns flags before read, clears after, keeps new changes.
`timescale 1ns/10ps
`default_nettype none

module umcs_top (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire umcs_pkg::umcs_modem_t modem_in_n,
	input  wire logic                 tx_serial,
	input  wire logic                 rx_pin,
	input  wire logic                 auto_rts_n,
	input  wire logic                 xoff_seen,
	input  wire logic                 irq_req,
	output logic                      rx_serial,
	output logic                      rts_n,
	output logic                      dtr_n,
	output logic                      general_output_pin,
	output logic                      channel_irq_out,
	output logic                      channel_irq_oe,
	output logic                      baud_clk_en,
	output logic                      xon_any_en,
	output logic                      fifo_rdy_en,
	output logic                      irq
);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	localparam int EV_LAST = umcs_pkg::EV_W - 1;

	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic [7:0]  wbyte;
	logic [7:0]  int_en_r;
	logic [7:0]  mctl_r;
	logic [7:0]  efeat_r;
	logic [7:0]  flow_thr_r;
	logic [7:0]  trig_lvl_r;
	logic [3:0]  delta_r;
	logic [3:0]  line_prev_r;
	logic [EV_LAST:0] evt_r;
	logic [EV_LAST:0] evt_mask_r;
	logic        rts_prev_r;
	logic        cts_prev_r;
	logic [1:0]  pre_cnt_r;
	logic [3:0]  line_now;
	logic [3:0]  chg;
	logic [EV_LAST:0] evt_set;
	logic        gate_ok;
	logic        rts_line;

	assign wbyte   = pwdata[7:0];
	assign pready  = 1'b1;
	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & penable & ~pwrite;
	assign gate_ok = mctl_r[umcs_pkg::MC_GATE];

	function automatic logic is_mapped(input logic [7:0] a, input logic g);
		case (a)
			umcs_pkg::ADDR_INT_EN, umcs_pkg::ADDR_MCTL, umcs_pkg::ADDR_MSTAT,
			umcs_pkg::ADDR_EFEAT, umcs_pkg::ADDR_EVT_ST, umcs_pkg::ADDR_EVT_MASK,
			umcs_pkg::ADDR_LINE_IN: is_mapped = 1'b1;
			// R2: gated access
			umcs_pkg::ADDR_FLOW_THR, umcs_pkg::ADDR_TRIG_LVL: is_mapped = g;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	assign mapped  = is_mapped(paddr, gate_ok);
	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			mctl_r <= umcs_pkg::RST_BYTE;
		end else if (wr_acc && paddr == umcs_pkg::ADDR_MCTL) begin
			mctl_r[4:0] <= wbyte[4:0];
			// R4: upper bits locked
			if (efeat_r[umcs_pkg::EF_WR_EN])
				mctl_r[7:5] <= wbyte[7:5];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			int_en_r <= umcs_pkg::RST_BYTE;
		end else if (wr_acc && paddr == umcs_pkg::ADDR_INT_EN) begin
			int_en_r[3:0] <= wbyte[3:0];
			// R17: upper bits locked
			if (efeat_r[umcs_pkg::EF_WR_EN])
				int_en_r[7:4] <= wbyte[7:4];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			efeat_r    <= umcs_pkg::RST_BYTE;
			flow_thr_r <= umcs_pkg::RST_BYTE;
			trig_lvl_r <= umcs_pkg::RST_BYTE;
		end else if (wr_acc) begin
			if (paddr == umcs_pkg::ADDR_EFEAT)
				efeat_r <= wbyte;
			// R2: gated writes
			if (gate_ok && paddr == umcs_pkg::ADDR_FLOW_THR)
				flow_thr_r <= wbyte;
			if (gate_ok && paddr == umcs_pkg::ADDR_TRIG_LVL)
				trig_lvl_r <= wbyte;
		end
	end

	// ----------------------------------------------------------------
	// Modem lines
	// ----------------------------------------------------------------
	// R5: loop source select
	// R6: loop-back mapping
	// R11: inverted inputs
	always_comb begin
		if (mctl_r[umcs_pkg::MC_LOOP])
			line_now = {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]};
		else
			line_now = ~{modem_in_n.cd, modem_in_n.ri, modem_in_n.dsr, modem_in_n.cts};
	end

	// R5: TX looped to RX
	assign rx_serial = mctl_r[umcs_pkg::MC_LOOP] ? tx_serial : rx_pin;

	// R12: any-edge detect
	// R13: RI rising only
	assign chg = {line_now[3] ^ line_prev_r[3],
			line_now[2] & ~line_prev_r[2],
			line_now[1] ^ line_prev_r[1],
			line_now[0] ^ line_prev_r[0]};

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			line_prev_r <= 4'h0;
		else
			line_prev_r <= line_now;
	end

	// R18: set wins over read clear
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			delta_r <= 4'h0;
		else if (rd_acc && paddr == umcs_pkg::ADDR_MSTAT)
			delta_r <= chg;
		else
			delta_r <= delta_r | chg;
	end

	// R9: RTS ownership
	assign rts_line = efeat_r[umcs_pkg::EF_AUTO_RTS] ? auto_rts_n : ~mctl_r[umcs_pkg::MC_RTS];

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			general_output_pin <= 1'b1;
		end else begin
			rts_n <= rts_line;
			// R10: DTR drive
			dtr_n <= ~mctl_r[umcs_pkg::MC_DTR];
			// R7: output pin level
			general_output_pin <= ~mctl_r[umcs_pkg::MC_IRQ_EN];
		end
	end

	// R1: prescaler
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			pre_cnt_r <= 2'h0;
		else
			pre_cnt_r <= pre_cnt_r + 2'h1;
	end
	assign baud_clk_en = ~mctl_r[umcs_pkg::MC_PRESCALE] | (pre_cnt_r == umcs_pkg::PRESCALE_DIV);

	// R3: resume on any char
	assign xon_any_en  = mctl_r[umcs_pkg::MC_XON_ANY];
	// R8: ready summary enable
	assign fifo_rdy_en = mctl_r[umcs_pkg::MC_FRDY];

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cts_prev_r <= 1'b1;
			rts_prev_r <= 1'b1;
		end else begin
			cts_prev_r <= modem_in_n.cts;
			rts_prev_r <= rts_line;
		end
	end

	// R14: per-source enables
	// R15: inactive-going edges
	always_comb begin
		evt_set = '0;
		evt_set[umcs_pkg::EV_MSR]  = |chg & int_en_r[umcs_pkg::IE_MODEM];
		evt_set[umcs_pkg::EV_CTS]  = modem_in_n.cts & ~cts_prev_r & int_en_r[umcs_pkg::IE_CTS];
		evt_set[umcs_pkg::EV_RTS]  = rts_line & ~rts_prev_r & int_en_r[umcs_pkg::IE_RTS];
		evt_set[umcs_pkg::EV_XOFF] = xoff_seen & int_en_r[umcs_pkg::IE_XOFF];
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			evt_r <= '0;
		else if (wr_acc && paddr == umcs_pkg::ADDR_EVT_ST)
			evt_r <= (evt_r & ~wbyte[EV_LAST:0]) | evt_set;
		else
			evt_r <= evt_r | evt_set;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			evt_mask_r <= '0;
		else if (wr_acc && paddr == umcs_pkg::ADDR_EVT_MASK)
			evt_mask_r <= wbyte[EV_LAST:0];
	end

	// R16: interrupt combine
	// Mask bit set hides a source; reset value leaves every source visible
	assign irq = |(evt_r & ~evt_mask_r) | irq_req;
	// R7: irq tri-state control
	assign channel_irq_oe  = mctl_r[umcs_pkg::MC_IRQ_EN];
	assign channel_irq_out = irq;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				umcs_pkg::ADDR_INT_EN:   prdata <= {24'h0, int_en_r};
				umcs_pkg::ADDR_MCTL:     prdata <= {24'h0, mctl_r};
				// R18: pre-read flags
				umcs_pkg::ADDR_MSTAT:    prdata <= {24'h0, line_now, delta_r | chg};
				umcs_pkg::ADDR_EFEAT:    prdata <= {24'h0, efeat_r};
				umcs_pkg::ADDR_FLOW_THR: prdata <= gate_ok ? {24'h0, flow_thr_r} : 32'h0;
				umcs_pkg::ADDR_TRIG_LVL: prdata <= gate_ok ? {24'h0, trig_lvl_r} : 32'h0;
				umcs_pkg::ADDR_EVT_ST:   prdata <= {28'h0, evt_r};
				umcs_pkg::ADDR_EVT_MASK: prdata <= {28'h0, evt_mask_r};
				umcs_pkg::ADDR_LINE_IN:  prdata <= {28'h0, rts_n, dtr_n, line_prev_r[1:0]};
				default:                 prdata <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	lock_mctl_a: assert property (@(posedge clock) disable iff (reset) // R4
		(wr_acc && paddr == umcs_pkg::ADDR_MCTL && !efeat_r[umcs_pkg::EF_WR_EN])
		|=> mctl_r[7:5] == $past(mctl_r[7:5])) else $error("mctl upper bits changed");

	lock_int_en_a: assert property (@(posedge clock) disable iff (reset) // R17
		(wr_acc && paddr == umcs_pkg::ADDR_INT_EN && !efeat_r[umcs_pkg::EF_WR_EN])
		|=> int_en_r[7:4] == $past(int_en_r[7:4])) else $error("enable upper bits changed");

	loop_map_a: assert property (@(posedge clock) disable iff (reset) // R6
		mctl_r[umcs_pkg::MC_LOOP] |-> line_now == {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]})
		else $error("loop mapping wrong");

	loop_rx_a: assert property (@(posedge clock) disable iff (reset) // R5
		mctl_r[umcs_pkg::MC_LOOP] |-> rx_serial == tx_serial) else $error("loop rx wrong");

	dtr_drive_a: assert property (@(posedge clock) disable iff (reset) // R10
		##1 dtr_n == !$past(mctl_r[umcs_pkg::MC_DTR])) else $error("dtr wrong");

	gpo_pin_a: assert property (@(posedge clock) disable iff (reset) // R7
		##1 general_output_pin == !$past(mctl_r[umcs_pkg::MC_IRQ_EN]))
		else $error("output pin wrong");

	ri_rise_a: assert property (@(posedge clock) disable iff (reset) // R13
		(!$past(line_now[2]) && line_now[2] && !rd_acc) |=> delta_r[2]) else $error("ri lost");

	cts_keep_a: assert property (@(posedge clock) disable iff (reset) // R12
		(delta_r[0] && !(rd_acc && paddr == umcs_pkg::ADDR_MSTAT)) |=> delta_r[0])
		else $error("delta cleared");

	irq_on_a: assert property (@(posedge clock) disable iff (reset) // R16
		|(evt_r & ~evt_mask_r) |-> irq) else $error("irq missing");

	ier_rst_a: assert property (@(posedge clock) disable iff (reset) // R14
		(!int_en_r[umcs_pkg::IE_CTS] && !evt_r[umcs_pkg::EV_CTS] && !wr_acc)
		|=> !evt_r[umcs_pkg::EV_CTS]) else $error("cts event while disabled");

	// ----------------------------------------------------------------
	// Checks: control outputs and register gating
	// ----------------------------------------------------------------
	// R1: undivided clock
	baud_full_a: assert property (@(posedge clock) disable iff (reset) // R1
		!mctl_r[umcs_pkg::MC_PRESCALE] |-> baud_clk_en) else $error("baud enable missing");

	// R1: divided clock
	baud_div_a: assert property (@(posedge clock) disable iff (reset) // R1
		(mctl_r[umcs_pkg::MC_PRESCALE] && baud_clk_en) ##1 mctl_r[umcs_pkg::MC_PRESCALE]
		|-> !baud_clk_en) else $error("baud enable too often");

	// R2: gate closed
	gate_hold_a: assert property (@(posedge clock) disable iff (reset) // R2
		(wr_acc && paddr == umcs_pkg::ADDR_FLOW_THR && !gate_ok)
		|=> flow_thr_r == $past(flow_thr_r)) else $error("threshold written while gated");

	xon_any_a: assert property (@(posedge clock) disable iff (reset) // R3
		xon_any_en == mctl_r[umcs_pkg::MC_XON_ANY]) else $error("resume enable wrong");

	irq_oe_a: assert property (@(posedge clock) disable iff (reset) // R7
		channel_irq_oe == mctl_r[umcs_pkg::MC_IRQ_EN]) else $error("irq enable wrong");

	frdy_en_a: assert property (@(posedge clock) disable iff (reset) // R8
		fifo_rdy_en == mctl_r[umcs_pkg::MC_FRDY]) else $error("ready enable wrong");

	// R9: software owns RTS
	rts_drive_a: assert property (@(posedge clock) disable iff (reset) // R9
		!efeat_r[umcs_pkg::EF_AUTO_RTS] |=> rts_n == !$past(mctl_r[umcs_pkg::MC_RTS]))
		else $error("rts wrong");

	// ----------------------------------------------------------------
	// Checks: status and interrupts
	// ----------------------------------------------------------------
	line_inv_a: assert property (@(posedge clock) disable iff (reset) // R11
		!mctl_r[umcs_pkg::MC_LOOP] |-> line_now == ~{modem_in_n.cd, modem_in_n.ri,
		modem_in_n.dsr, modem_in_n.cts}) else $error("line view wrong");

	cd_delta_a: assert property (@(posedge clock) disable iff (reset) // R12
		(line_now[3] != line_prev_r[3]) |=> delta_r[3]) else $error("cd change lost");

	// R12: read clears when quiet
	mstat_clr_a: assert property (@(posedge clock) disable iff (reset) // R12
		(rd_acc && paddr == umcs_pkg::ADDR_MSTAT && chg == 4'h0) |=> delta_r == 4'h0)
		else $error("flags not cleared");

	ri_fall_a: assert property (@(posedge clock) disable iff (reset) // R13
		(line_prev_r[2] && !line_now[2] && !delta_r[2]) |=> !delta_r[2])
		else $error("ri fall flagged");

	cts_evt_a: assert property (@(posedge clock) disable iff (reset) // R15
		(int_en_r[umcs_pkg::IE_CTS] && modem_in_n.cts && !cts_prev_r)
		|=> evt_r[umcs_pkg::EV_CTS]) else $error("cts event lost");

	// R18: read shows flags before clear
	rd_flags_a: assert property (@(posedge clock) disable iff (reset) // R18
		(psel && !penable && !pwrite && paddr == umcs_pkg::ADDR_MSTAT)
		|=> prdata[3:0] == $past(delta_r | chg)) else $error("read flags wrong");

endmodule : umcs_top

`default_nettype wire

// [umcs_pkg.sv]
// Package for the modem control and status block
package umcs_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INT_EN   = 8'h00;
	localparam logic [7:0] ADDR_MCTL     = 8'h04;
	localparam logic [7:0] ADDR_MSTAT    = 8'h08;
	localparam logic [7:0] ADDR_EFEAT    = 8'h0c;
	localparam logic [7:0] ADDR_FLOW_THR = 8'h10;
	localparam logic [7:0] ADDR_TRIG_LVL = 8'h14;
	localparam logic [7:0] ADDR_EVT_ST   = 8'h18;
	localparam logic [7:0] ADDR_EVT_MASK = 8'h1c;
	localparam logic [7:0] ADDR_LINE_IN  = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MC_PRESCALE  = 7;
	localparam int MC_GATE      = 6;
	localparam int MC_XON_ANY   = 5;
	localparam int MC_LOOP      = 4;
	localparam int MC_IRQ_EN    = 3;
	localparam int MC_FRDY      = 2;
	localparam int MC_RTS       = 1;
	localparam int MC_DTR       = 0;
	localparam int EF_WR_EN     = 4;
	localparam int EF_AUTO_RTS  = 6;
	localparam int IE_CTS       = 7;
	localparam int IE_RTS       = 6;
	localparam int IE_XOFF      = 5;
	localparam int IE_MODEM     = 3;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [1:0] PRESCALE_DIV = 2'h3;

	// Event status bits
	localparam int EV_MSR  = 0;
	localparam int EV_CTS  = 1;
	localparam int EV_RTS  = 2;
	localparam int EV_XOFF = 3;
	localparam int EV_W    = 4;

	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} umcs_modem_t;

endpackage : umcs_pkg

// [umcs_modem_model.sv]
// Modem-side model that drives the active-low status lines
`timescale 1ns/10ps
`default_nettype none

module umcs_modem_model (
	input  wire logic                  clock,
	input  wire logic                  reset,
	input  wire umcs_pkg::umcs_modem_t line_on,
	output var  umcs_pkg::umcs_modem_t modem_in_n
);
	// ----------------------------------------------------------------
	// Line drivers
	// ----------------------------------------------------------------
	// Lines move only after an edge: the block samples them synchronously
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			modem_in_n <= 4'hf;
		end else begin
			modem_in_n <= ~line_on;
		end
	end
endmodule : umcs_modem_model
`default_nettype wire

// [umcs_top_bench.sv]
// Testbench for the modem control and status block
`timescale 1ns/10ps
`default_nettype none

module umcs_top_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                  clock = 1'b0;
	logic                  reset = 1'b1;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [7:0]            paddr = 8'h00;
	logic [31:0]           pwdata = 32'h0;
	logic                  tx_serial = 1'b1;
	logic                  rx_pin = 1'b1;
	logic                  auto_rts_n = 1'b1;
	logic                  xoff_seen = 1'b0;
	logic                  irq_req = 1'b0;
	umcs_pkg::umcs_modem_t line_on = 4'h0;
	umcs_pkg::umcs_modem_t modem_in_n;
	logic [31:0]           prdata, rd;
	logic                  pready, pslverr, err, rx_serial, rts_n, dtr_n, gop;
	logic                  irq_out, irq_oe, baud_en, xon_en, frdy_en, irq;
	int                    fails = 0;
	int                    total_checks = 0;
	int                    n;

	umcs_top umcs_top_i (
		.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.modem_in_n(modem_in_n), .tx_serial(tx_serial), .rx_pin(rx_pin),
		.auto_rts_n(auto_rts_n), .xoff_seen(xoff_seen), .irq_req(irq_req),
		.rx_serial(rx_serial), .rts_n(rts_n), .dtr_n(dtr_n), .general_output_pin(gop),
		.channel_irq_out(irq_out), .channel_irq_oe(irq_oe), .baud_clk_en(baud_en),
		.xon_any_en(xon_en), .fifo_rdy_en(frdy_en), .irq(irq)
	);

	umcs_modem_model umcs_modem_model_i (
		.clock(clock), .reset(reset), .line_on(line_on), .modem_in_n(modem_in_n)
	);

	always #10 clock = ~clock;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic chk_pin(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_pin

	// Request held until pready is seen; a stuck slave ends the run
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			fails++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		chk_reg(nm, {24'h0, e}, rd);
	endtask : rdchk

	task automatic lines(input logic [3:0] v);
		line_on <= v;
		repeat (3) @(posedge clock);
	endtask : lines

	task automatic baud(input int e);
		n = 0;
		repeat (8) begin
			@(posedge clock);
			n += int'(baud_en === 1'b1);
		end
		chk_reg("baud", e, n);
	endtask : baud

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk_pin("rts_n", 1'b1, rts_n);
		chk_pin("dtr_n", 1'b1, dtr_n);
		chk_pin("gpo", 1'b1, gop);
		chk_pin("irq_oe", 1'b0, irq_oe);
		rdchk("int_en", umcs_pkg::ADDR_INT_EN, 8'h00);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h00);
		baud(8);
		$display("test reset done");
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'he3);
		rdchk("mctl", umcs_pkg::ADDR_MCTL, 8'h03);
		chk_pin("rts_n", 1'b0, rts_n);
		chk_pin("dtr_n", 1'b0, dtr_n);
		apb(1'b1, umcs_pkg::ADDR_INT_EN, 32'hf0);
		rdchk("int_en", umcs_pkg::ADDR_INT_EN, 8'h00);
		apb(1'b1, umcs_pkg::ADDR_EFEAT, 32'h10);
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'he0);
		rdchk("mctl", umcs_pkg::ADDR_MCTL, 8'he0);
		chk_pin("xon", 1'b1, xon_en);
		baud(2);
		apb(1'b1, umcs_pkg::ADDR_FLOW_THR, 32'h5a);
		rdchk("thr", umcs_pkg::ADDR_FLOW_THR, 8'h5a);
		chk_pin("err", 1'b0, err);
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'h0c);
		// Output pin is registered: one more edge before it shows
		@(posedge clock);
		@(negedge clock);
		chk_pin("irq_oe", 1'b1, irq_oe);
		chk_pin("gpo", 1'b0, gop);
		chk_pin("frdy", 1'b1, frdy_en);
		chk_pin("xon", 1'b0, xon_en);
		rdchk("thr", umcs_pkg::ADDR_FLOW_THR, 8'h00);
		chk_pin("err", 1'b1, err);
		rdchk("hole", 8'h24, 8'h00);
		chk_pin("err", 1'b1, err);
		$display("test control done");
		lines(4'h1);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h11);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h10);
		lines(4'h5);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h54);
		lines(4'h1);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h10);
		lines(4'hb);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'hba);
		lines(4'h0);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h0b);
		$display("test status done");
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'h1f);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'hff);
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'h11);
		rdchk("mstat", umcs_pkg::ADDR_MSTAT, 8'h29);
		tx_serial <= 1'b0;
		@(negedge clock);
		chk_pin("rx", 1'b0, rx_serial);
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'h00);
		@(negedge clock);
		chk_pin("rx", 1'b1, rx_serial);
		$display("test loop done");
		apb(1'b1, umcs_pkg::ADDR_INT_EN, 32'he0);
		rdchk("int_en", umcs_pkg::ADDR_INT_EN, 8'he0);
		lines(4'h1);
		rdchk("evt", umcs_pkg::ADDR_EVT_ST, 8'h00);
		lines(4'h0);
		rdchk("evt", umcs_pkg::ADDR_EVT_ST, 8'h02);
		chk_pin("irq", 1'b1, irq);
		chk_pin("irq_out", 1'b1, irq_out);
		apb(1'b1, umcs_pkg::ADDR_EVT_MASK, 32'h02);
		@(negedge clock);
		chk_pin("irq", 1'b0, irq);
		apb(1'b1, umcs_pkg::ADDR_EVT_MASK, 32'h00);
		apb(1'b1, umcs_pkg::ADDR_EVT_ST, 32'h02);
		@(negedge clock);
		chk_pin("irq", 1'b0, irq);
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'h02);
		apb(1'b1, umcs_pkg::ADDR_MCTL, 32'h00);
		@(posedge clock);
		xoff_seen <= 1'b1;
		@(posedge clock);
		xoff_seen <= 1'b0;
		rdchk("evt", umcs_pkg::ADDR_EVT_ST, 8'h0c);
		apb(1'b1, umcs_pkg::ADDR_EVT_ST, 32'h0f);
		irq_req <= 1'b1;
		@(negedge clock);
		chk_pin("irq", 1'b1, irq);
		apb(1'b1, umcs_pkg::ADDR_EFEAT, 32'h50);
		auto_rts_n <= 1'b0;
		irq_req <= 1'b0;
		repeat (2) @(negedge clock);
		chk_pin("rts_n", 1'b0, rts_n);
		$display("test interrupt done");
		end_sim();
	end
endmodule : umcs_top_bench
`default_nettype wire
